//--- bench/ccp_core_tb.sv
`timescale 1ns/1ps
module ccp_core_tb;
  import ccp_pkg::*;
  localparam int STEP = 400;
  localparam int TOTAL = 13200;
  localparam int ON_MAX = PER_CYC * DUTY_NUM / 4;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic supply = 1'b0;
  logic [11:0] pwm_at = 12'hfff;
  logic [11:0] peak_at = 12'hfff;
  logic [11:0] burst_at = 12'hfff;
  logic [11:0] ss_at = 12'd100;
  ccp_sense_t sense;
  ccp_bus_t bus = '0;
  logic [DATA_W-1:0] rdata;
  logic gate;
  logic [STEP_W-1:0] level;
  logic sink;
  logic [31:0] rv;
  int seed = 38;
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;
  int w, t0, t1, lv, tl, hi, viol, pa, pmin, pmax;

  always #2 ref_clk = ~ref_clk;
  always @(posedge ref_clk) cyc <= cyc + 1;

  ccp_core #(.SS_STEP_CYCLES(STEP), .SS_TOTAL_CYCLES(TOTAL), .JIT_STEP_PERIODS(1)) dut_u (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_sense(sense), .i_bus(bus), .o_rdata(rdata),
    .o_gate(gate), .o_softstart_limit_level(level), .o_ss_sink_en(sink));
  ccp_sense_model model_u (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_gate(gate), .i_supply_ok(supply), .i_pwm_at(pwm_at),
    .i_peak_at(peak_at), .i_burst_at(burst_at), .i_ss_at(ss_at), .o_sense(sense));

  task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function logic in_rng(input int v, input int lo, input int hi_lim);
    return (v >= lo) && (v <= hi_lim);
  endfunction : in_rng

  task wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task rd(input logic [3:0] a);
    @(posedge ref_clk);
    bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk);
    bus.rd <= 1'b0;
    @(negedge ref_clk);
    rv = rdata;
  endtask : rd

  // waits until gate is high and counts the high cycles left in that pulse
  task pulse();
    int k;
    k = 0;
    while (gate !== 1'b1 && k < 3000)
    begin
      @(negedge ref_clk);
      k++;
    end
    t0 = t1;
    t1 = cyc;
    w = 0;
    while (gate === 1'b1 && w < 3000)
    begin
      @(negedge ref_clk);
      w++;
    end
  endtask : pulse

  task report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop

  initial
  begin
    repeat (100000) @(posedge ref_clk);
    bad_count++;
    report_and_stop();
  end

  initial
  begin
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    viol = 0;
    repeat (200)
    begin
      @(negedge ref_clk);
      if (gate !== 1'b0) viol++;
    end
    chk("gate_lockout", viol, 0);
    rd(STAT_OFS);
    chk("step_reset", rv[5:0], 6'h00);
    chk("supply_low", rv[STAT_SUPPLY_BIT], 1'b0);
    rd(4'h8);
    chk("unmapped", rv, 32'h0);
    wr(CTRL_OFS, 32'h1);
    rd(CTRL_OFS);
    chk("ctrl_burst", rv, 32'h1);
    wr(CTRL_OFS, 32'h0);
    $display("test reset_bus done");
    @(posedge ref_clk);
    supply <= 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("sink_on", sink, 1'b1);
    lv = 0;
    tl = cyc;
    hi = 0;
    viol = 0;
    for (int i = 0; i < TOTAL; i++)
    begin
      @(negedge ref_clk);
      if (level !== lv[5:0])
      begin
        chk("step_inc", level, lv + 1);
        if (lv > 0) chk("step_gap", cyc - tl, STEP);
        lv = level;
        tl = cyc;
      end
      hi = (gate === 1'b1) ? hi + 1 : 0;
      if (hi > ON_MAX * lv / SS_STEPS + 8) viol++;
    end
    chk("ramp_duty", viol, 0);
    repeat (20) @(negedge ref_clk);
    chk("ss_sink_off", sink, 1'b0);
    chk("ss_level", level, SS_STEPS);
    rd(STAT_OFS);
    chk("ss_done", rv[STAT_DONE_BIT], 1'b1);
    chk("jit_on", rv[STAT_JIT_BIT], 1'b1);
    chk("supply_bit", rv[STAT_SUPPLY_BIT], 1'b1);
    $display("test softstart done");
    pulse();
    pmin = 99999;
    pmax = 0;
    repeat (5)
    begin
      pa = 100 + ($random(seed) & 1023);
      @(posedge ref_clk);
      pwm_at <= pa[11:0];
      pulse();
      chk("pwm_width", in_rng(w, pa, pa + 8), 1'b1);
      chk("period", in_rng(t1 - t0, PER_CYC - JIT_AMP, PER_CYC + JIT_AMP), 1'b1);
      pmin = (t1 - t0 < pmin) ? t1 - t0 : pmin;
      pmax = (t1 - t0 > pmax) ? t1 - t0 : pmax;
    end
    chk("jitter_moves", pmin != pmax, 1'b1);
    @(posedge ref_clk);
    pwm_at <= 12'd1500;
    peak_at <= 12'd300;
    pulse();
    chk("peak_width", in_rng(w, 300, 308), 1'b1);
    @(posedge ref_clk);
    pwm_at <= 12'hfff;
    peak_at <= 12'hfff;
    pulse();
    chk("max_duty", in_rng(w, ON_MAX - JIT_AMP, ON_MAX + JIT_AMP), 1'b1);
    @(posedge ref_clk);
    pwm_at <= 12'd10;
    pulse();
    chk("blank_norm", in_rng(w, LEB_NORM_CYC, LEB_NORM_CYC + 8), 1'b1);
    @(posedge ref_clk);
    pwm_at <= 12'd600;
    burst_at <= 12'd200;
    pulse();
    chk("burst_ignored", in_rng(w, 600, 608), 1'b1);
    wr(CTRL_OFS, 32'h1);
    pulse();
    chk("burst_limit", in_rng(w, 200, 208), 1'b1);
    @(posedge ref_clk);
    burst_at <= 12'd10;
    pulse();
    chk("blank_burst", in_rng(w, LEB_BURST_CYC, LEB_BURST_CYC + 8), 1'b1);
    $display("test pwm done");
    wr(CTRL_OFS, 32'h2);
    repeat (10) @(negedge ref_clk);
    chk("restart_sink", sink, 1'b1);
    chk("restart_level", level, 6'h00);
    repeat (1000) @(negedge ref_clk);
    // first call may land inside a pulse
    pulse();
    pulse();
    chk("ss_width", in_rng(w, 100, 108), 1'b1);
    @(posedge ref_clk);
    supply <= 1'b0;
    repeat (10) @(negedge ref_clk);
    chk("drop_gate", gate, 1'b0);
    chk("drop_level", level, 6'h00);
    chk("drop_sink", sink, 1'b0);
    viol = 0;
    repeat (3000)
    begin
      @(negedge ref_clk);
      if (gate !== 1'b0) viol++;
    end
    chk("drop_hold", viol, 0);
    @(posedge ref_clk);
    supply <= 1'b1;
    repeat (10) @(negedge ref_clk);
    chk("again_sink", sink, 1'b1);
    chk("again_level", level, 6'h00);
    $display("test restart done");
    report_and_stop();
  end
endmodule : ccp_core_tb

//--- bench/ccp_sense_model.sv
`timescale 1ns/1ps
module ccp_sense_model (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_gate,
  input wire logic i_supply_ok,
  input wire logic [11:0] i_pwm_at,
  input wire logic [11:0] i_peak_at,
  input wire logic [11:0] i_burst_at,
  input wire logic [11:0] i_ss_at,
  output ccp_pkg::ccp_sense_t o_sense
);
  import ccp_pkg::*;
  logic [11:0] on_q;
  logic [11:0] on_d;
  always_comb
  begin
    on_d = i_gate ? on_q + 12'h001 : 12'h000;
  end
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      on_q <= 12'h000;
    end
    else
    begin
      on_q <= on_d;
    end
  end
  // current ramps only while the switch conducts
  always_comb
  begin
    o_sense.supply_ok = i_supply_ok;
    o_sense.pwm_cmp = i_gate && (on_q >= i_pwm_at);
    o_sense.peak_cmp = i_gate && (on_q >= i_peak_at);
    o_sense.burst_cmp = i_gate && (on_q >= i_burst_at);
    o_sense.ss_cmp = i_gate && (on_q >= i_ss_at);
  end
endmodule : ccp_sense_model

//--- hdl/ccp_core.sv
// Overview of operation
// - gate off when current exceeds feedback
// - start soft-start when supply turns on
// - soft-start limit rises in 32 steps
// - soft-start counter advances every 300us
// - soft-start ends 10ms after switch-on
// - permitted duty climbs from zero to maximum
// - rerun soft-start on every restart attempt
// - 100kHz period, 4% jitter, 4ms jitter period
// - on-time never exceeds 0.75 duty
// - jitter only after soft-start completes
// - oscillator sets latch, comparators clear it
// - latch reset forces gate off immediately
// - gate held low under supply lockout
// - peak current resets latch cycle by cycle
// - blank sense path for all comparators
// - blanking 220ns normal, 180ns burst
// - burst comparator acts only in burst
// - supply off clears soft-start counter
`timescale 1ns/1ps
module ccp_core #(
  parameter int SS_STEP_CYCLES = ccp_pkg::SS_STEP_CYC,
  parameter int SS_TOTAL_CYCLES = ccp_pkg::SS_TIME_CYC,
  parameter int JIT_STEP_PERIODS = 1
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire ccp_pkg::ccp_sense_t i_sense,
  input wire ccp_pkg::ccp_bus_t i_bus,
  output logic [ccp_pkg::DATA_W-1:0] o_rdata,
  output logic o_gate,
  output logic [ccp_pkg::STEP_W-1:0] o_softstart_limit_level,
  output logic o_ss_sink_en
);
  import ccp_pkg::*;

  // three-stage synchronisers, change accepted when stages 2 and 3 agree
  logic [N_IN-1:0] s1_q, s2_q, s3_q, filt_q, filt_d;
  ccp_sense_t sn;

  genvar gi;
  generate
    for (gi = 0; gi < N_IN; gi++)
    begin : g_sync
      always_comb
      begin
        filt_d[gi] = (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : filt_q[gi];
      end
    end
  endgenerate

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      filt_q <= '0;
    end
    else
    begin
      s1_q <= i_sense;
      s2_q <= s1_q;
      s3_q <= s2_q;
      filt_q <= filt_d;
    end
  end

  assign sn = ccp_sense_t'(filt_q);

  // register port
  logic burst_q, burst_d, restart_q, restart_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic [DATA_W-1:0] stat;

  // soft-start and oscillator state
  ccp_ss_state_t ss_q, ss_d;
  logic [STEP_W-1:0] step_q, step_d;
  logic [31:0] tick_q, tick_d, tot_q, tot_d;
  logic [PER_W-1:0] per_q, per_d, target, on_max, on_lim;
  logic signed [JIT_W-1:0] jit_q, jit_d;
  logic jdir_q, jdir_d;
  logic [15:0] jper_q, jper_d;
  logic [LEB_W-1:0] leb_q, leb_d;
  logic latch_q, latch_d, sup_q, sup_d;
  logic set_req, rst_req, blanked, sense_rst, cyc_start, running;

  always_comb
  begin
    stat = '0;
    stat[STAT_STEP_LSB +: STEP_W] = step_q;
    stat[STAT_DONE_BIT] = (ss_q == CCP_SS_DONE);
    stat[STAT_LATCH_BIT] = latch_q;
    stat[STAT_GATE_BIT] = o_gate;
    stat[STAT_JIT_BIT] = (ss_q == CCP_SS_DONE);
    stat[STAT_SUPPLY_BIT] = sn.supply_ok;
    burst_d = burst_q;
    restart_d = 1'b0;
    rdata_d = '0;
    if (i_bus.wr && i_bus.addr == CTRL_OFS)
    begin
      burst_d = i_bus.wdata[CTRL_BURST_BIT];
      restart_d = i_bus.wdata[CTRL_RESTART_BIT];
    end
    if (i_bus.rd)
    begin
      unique case (i_bus.addr)
        CTRL_OFS: rdata_d[CTRL_BURST_BIT] = burst_q;
        STAT_OFS: rdata_d = stat;
        default: rdata_d = '0;
      endcase
    end
  end

  // oscillator with triangular jitter and duty ceiling
  always_comb
  begin
    running = (ss_q != CCP_SS_OFF);
    target = PER_W'(PER_CYC + int'(jit_q));
    on_max = PER_W'((int'(target) * DUTY_NUM) >> DUTY_SHIFT);
    on_lim = (ss_q == CCP_SS_RAMP) ?
      PER_W'((int'(on_max) * int'(step_q)) >> SS_SHIFT) : on_max;
    cyc_start = running && per_q == '0;
    per_d = '0;
    if (running && per_q < target - PER_W'(1))
      per_d = per_q + PER_W'(1);
    jit_d = jit_q;
    jdir_d = jdir_q;
    jper_d = jper_q;
    if (ss_q != CCP_SS_DONE)
    begin
      jit_d = '0;
      jdir_d = 1'b1;
      jper_d = '0;
    end
    else if (cyc_start)
    begin
      jper_d = jper_q + 16'h0001;
      if (int'(jper_q) >= JIT_STEP_PERIODS - 1)
      begin
        jper_d = '0;
        if (jdir_q)
        begin
          jit_d = jit_q + JIT_W'(1);
          if (int'(jit_q) >= JIT_AMP - 1)
            jdir_d = 1'b0;
        end
        else
        begin
          jit_d = jit_q - JIT_W'(1);
          if (int'(jit_q) <= 1 - JIT_AMP)
            jdir_d = 1'b1;
        end
      end
    end
  end

  // soft-start sequencer
  always_comb
  begin
    sup_d = sn.supply_ok;
    ss_d = ss_q;
    step_d = step_q;
    tick_d = tick_q;
    tot_d = tot_q;
    unique case (ss_q)
      CCP_SS_OFF:
      begin
        step_d = '0;
        tick_d = '0;
        tot_d = '0;
        if (sn.supply_ok && !sup_q)
          ss_d = CCP_SS_RAMP;
      end
      CCP_SS_RAMP:
      begin
        tot_d = tot_q + 32'h1;
        tick_d = tick_q + 32'h1;
        if (int'(tick_q) >= SS_STEP_CYCLES - 1)
        begin
          tick_d = '0;
          if (int'(step_q) < SS_STEPS)
            step_d = step_q + STEP_W'(1);
        end
        if (int'(tot_q) >= SS_TOTAL_CYCLES - 1)
        begin
          ss_d = CCP_SS_DONE;
          step_d = STEP_W'(SS_STEPS);
        end
      end
      CCP_SS_DONE: ss_d = CCP_SS_DONE;
      default: ss_d = CCP_SS_OFF;
    endcase
    if (restart_q && sn.supply_ok)
    begin
      ss_d = CCP_SS_RAMP;
      step_d = '0;
      tick_d = '0;
      tot_d = '0;
    end
    if (!sn.supply_ok)
    begin
      ss_d = CCP_SS_OFF;
      step_d = '0;
    end
  end

  // pwm latch with blanking of the sense comparators
  always_comb
  begin
    set_req = cyc_start;
    blanked = leb_q != '0 || set_req;
    sense_rst = !blanked && (sn.pwm_cmp
      || sn.peak_cmp
      || (sn.ss_cmp && ss_q == CCP_SS_RAMP)
      || (sn.burst_cmp && burst_q));
    rst_req = sense_rst || per_q >= on_lim || !sn.supply_ok || !running;
    leb_d = (leb_q != '0) ? leb_q - LEB_W'(1) : '0;
    if (set_req && !rst_req)
      leb_d = burst_q ? LEB_W'(LEB_BURST_CYC) : LEB_W'(LEB_NORM_CYC);
    if (rst_req)
      latch_d = 1'b0;
    else if (set_req)
      latch_d = 1'b1;
    else
      latch_d = latch_q;
  end

  assign o_gate = latch_q && !rst_req;
  assign o_rdata = rdata_q;
  assign o_softstart_limit_level = step_q;
  assign o_ss_sink_en = (ss_q == CCP_SS_RAMP);

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      burst_q <= 1'b0;
      restart_q <= 1'b0;
      rdata_q <= '0;
      ss_q <= CCP_SS_OFF;
      step_q <= '0;
      tick_q <= '0;
      tot_q <= '0;
      per_q <= '0;
      jit_q <= '0;
      jdir_q <= 1'b1;
      jper_q <= '0;
      leb_q <= '0;
      latch_q <= 1'b0;
      sup_q <= 1'b0;
    end
    else
    begin
      burst_q <= burst_d;
      restart_q <= restart_d;
      rdata_q <= rdata_d;
      ss_q <= ss_d;
      step_q <= step_d;
      tick_q <= tick_d;
      tot_q <= tot_d;
      per_q <= per_d;
      jit_q <= jit_d;
      jdir_q <= jdir_d;
      jper_q <= jper_d;
      leb_q <= leb_d;
      latch_q <= latch_d;
      sup_q <= sup_d;
    end
  end

  // checks
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence s_turn_on;
    $rose(latch_q);
  endsequence

  a_gate_current_off: assert property (sn.pwm_cmp && !blanked |-> !o_gate)
    else $error("gate on above feedback level");
  a_ss_start: assert property (ss_q == CCP_SS_OFF && sn.supply_ok && !sup_q |=> ss_q == CCP_SS_RAMP)
    else $error("soft-start did not begin");
  a_step_limit: assert property (int'(step_q) <= SS_STEPS)
    else $error("soft-start step beyond limit");
  a_step_tick: assert property (ss_q == CCP_SS_RAMP && ss_q == $past(ss_q)
    && $changed(step_q) && step_q != '0 |-> int'($past(tick_q)) == SS_STEP_CYCLES - 1)
    else $error("step advanced off schedule");
  a_ss_done: assert property (ss_q == CCP_SS_RAMP && int'(tot_q) == SS_TOTAL_CYCLES - 1
    && sn.supply_ok && !restart_q |=> ss_q == CCP_SS_DONE && !o_ss_sink_en)
    else $error("soft-start did not finish");
  a_duty_cap: assert property (o_gate |-> per_q < on_max)
    else $error("duty ceiling exceeded");
  a_jit_quiet: assert property (ss_q != CCP_SS_DONE |=> jit_q == '0)
    else $error("jitter before soft-start end");
  a_jit_range: assert property (int'(jit_q) <= JIT_AMP && int'(jit_q) >= -JIT_AMP)
    else $error("jitter out of range");
  a_uvlo_low: assert property (!sn.supply_ok |-> !o_gate ##1 !o_gate)
    else $error("gate on under lockout");
  a_uvlo_clear: assert property (!sn.supply_ok |=> step_q == '0 && ss_q == CCP_SS_OFF)
    else $error("soft-start not cleared");
  a_blank_hold: assert property ((s_turn_on and !$past(burst_q) && !rst_req)
    |-> (int'(leb_q) == LEB_NORM_CYC) ##1 (leb_q != '0)[*8])
    else $error("blanking too short");
  a_blank_burst: assert property ((s_turn_on and $past(burst_q))
    |-> int'(leb_q) == LEB_BURST_CYC)
    else $error("burst blanking wrong length");
  a_reset_wins: assert property (set_req && rst_req |=> !latch_q)
    else $error("set beat reset");
  a_restart_ss: assert property (restart_q && sn.supply_ok |=> ss_q == CCP_SS_RAMP && step_q == '0)
    else $error("restart skipped soft-start");
endmodule : ccp_core

//--- hdl/ccp_pkg.sv
package ccp_pkg;
  localparam int CLK_MHZ = 250;
  localparam int SW_FREQ_KHZ = 100;
  localparam int PER_CYC = CLK_MHZ * 1000 / SW_FREQ_KHZ;
  localparam int JIT_PCT = 4;
  localparam int JIT_PERIOD_MS = 4;
  localparam int JIT_AMP = PER_CYC * JIT_PCT / 100;
  localparam int DUTY_NUM = 3;
  localparam int DUTY_SHIFT = 2;
  localparam int SS_STEPS = 32;
  localparam int SS_SHIFT = 5;
  localparam int SS_STEP_US = 300;
  localparam int SS_STEP_CYC = SS_STEP_US * CLK_MHZ;
  localparam int SS_TIME_MS = 10;
  localparam int SS_TIME_CYC = SS_TIME_MS * 1000 * CLK_MHZ;
  localparam int LEB_NORM_NS = 220;
  localparam int LEB_BURST_NS = 180;
  localparam int LEB_NORM_CYC = (LEB_NORM_NS * CLK_MHZ + 999) / 1000;
  localparam int LEB_BURST_CYC = (LEB_BURST_NS * CLK_MHZ + 999) / 1000;
  localparam int PER_W = 13;
  localparam int JIT_W = 9;
  localparam int STEP_W = 6;
  localparam int LEB_W = 7;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] CTRL_OFS = 4'h0;
  localparam logic [ADDR_W-1:0] STAT_OFS = 4'h4;
  localparam int CTRL_BURST_BIT = 0;
  localparam int CTRL_RESTART_BIT = 1;
  localparam int STAT_STEP_LSB = 0;
  localparam int STAT_DONE_BIT = 6;
  localparam int STAT_LATCH_BIT = 7;
  localparam int STAT_GATE_BIT = 8;
  localparam int STAT_JIT_BIT = 9;
  localparam int STAT_SUPPLY_BIT = 10;
  localparam int N_IN = 5;

  typedef enum logic [1:0] {
    CCP_SS_OFF = 2'b00,
    CCP_SS_RAMP = 2'b01,
    CCP_SS_DONE = 2'b10
  } ccp_ss_state_t;

  typedef struct packed {
    logic supply_ok;
    logic burst_cmp;
    logic peak_cmp;
    logic ss_cmp;
    logic pwm_cmp;
  } ccp_sense_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } ccp_bus_t;
endpackage : ccp_pkg
